// file: rtl/gst_timer.sv
`timescale 1ns/100ps
`include "gst_map.svh"

module gst_timer (
	input  wire logic                clock_i,     // system clock
	input  wire logic                arst_n_i,    // power-on reset
	input  wire logic                clk_en_i,    // freezes all state
	input  wire logic                soft_rst_i,  // non-power-on reset
	input  wire gst_pkg::gst_avs_req_s avs_req_i, // avalon request
	input  wire logic [17:0]         clk_src_i,   // count clock sources
	input  wire logic [24:0]         gate_src_i,  // gate sources
	output logic [31:0]              avs_readdata_o,    // read data
	output logic                     avs_waitrequest_o, // stall
	output logic                     overflow_o,  // wrap pulse
	output logic                     gate_level_o // current gate
);
	import gst_pkg::*;

	gst_state_s st;
	gst_state_s n;
	logic       tick;
	logic       raw;
	logic       gsig;
	logic       act;
	logic       gate_open;
	logic       psk;
	logic       inc;
	logic       wrap;
	logic       cap;
	logic       acc;
	logic [7:0] rdv;
	logic [7:0] d;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// true when a byte address hits a register index
	function automatic logic hit(input logic [11:0] a,
		input logic [11:0] idx);
		return a == {idx[9:0], 2'h0};
	endfunction : hit

	// last prescaler count before a prescaled tick
	function automatic logic [2:0] ps_top(input logic [1:0] ps);
		case (ps)
		2'h0: ps_top = 3'h0;
		2'h1: ps_top = 3'h1;
		2'h2: ps_top = 3'h3;
		default: ps_top = 3'h7;
		endcase
	endfunction : ps_top

	// ---------------------------------------------------------------
	// count clock selection
	// ---------------------------------------------------------------
	gst_tick_gen u_tick (
		.clock_i   (clock_i),
		.arst_n_i  (arst_n_i),
		.clk_en_i  (clk_en_i),
		.clk_src_i (clk_src_i),
		.sel_i     (st.csel),
		.nsync_i   (st.nsync),
		.tick_o    (tick)
	);

	// ---------------------------------------------------------------
	// next-state logic
	// ---------------------------------------------------------------
	always_comb begin
		n = st;
		psk = 1'b0;
		inc = 1'b0;
		wrap = 1'b0;
		rdv = 8'h00;
		d = avs_req_i.writedata[7:0];
		n.ovf_pulse = 1'b0;

		// gate source and toggle stage
		raw = (st.gsel <= `GST_GS_LAST) ? gate_src_i[st.gsel] : 1'b0;
		n.gate_d = raw;
		if (!st.tgl) begin
			n.tff = 1'b0;
		end else if (raw && !st.gate_d) begin
			n.tff = ~st.tff;
		end
		gsig = st.tgl ? st.tff : raw;
		act = st.pol ? gsig : ~gsig;
		n.act_d = act;

		// single-pulse acquisition: arm, run one pulse, done
		case (st.sp)
		GST_SP_ARMED: begin
			if (act && !st.act_d) n.sp = GST_SP_RUN;
		end
		GST_SP_RUN: begin
			if (!act) n.sp = GST_SP_IDLE;
		end
		default: begin
		end
		endcase
		if (!st.spm) n.sp = GST_SP_IDLE;
		gate_open = st.spm ? (st.sp == GST_SP_RUN && act) : act;
		n.gate_level = gate_open;

		// prescaler; >= covers a code lowered mid-count
		if (st.on && tick) begin
			if (st.pre >= ps_top(st.ps)) begin
				n.pre = 3'h0;
				psk = 1'b1;
			end else begin
				n.pre = st.pre + 3'h1;
			end
		end
		inc = psk && (!st.ge || gate_open);
		if (inc) begin
			n.count = st.count + 16'h0001;
			wrap = (st.count == `GST_CNT_MAX);
		end

		// bus: data is fetched while waitrequest is high, so the
		// answer takes exactly one stall cycle while clk_en_i is high and soft_rst_i low
		cap = avs_req_i.read && st.busy_n;
		acc = (avs_req_i.read || avs_req_i.write) && !st.busy_n;
		n.busy_n = !((avs_req_i.read || avs_req_i.write) && st.busy_n);
		if (cap) begin
			if (hit(avs_req_i.address, `GST_IDX_CNT_LO)) begin
				rdv = st.count[7:0];
				if (st.wide) n.hi_rd_buf = st.count[15:8];
			end else if (hit(avs_req_i.address, `GST_IDX_CNT_HI)) begin
				rdv = st.wide ? st.hi_rd_buf : st.count[15:8];
			end else if (hit(avs_req_i.address, `GST_IDX_CTRL)) begin
				rdv = {2'h0, st.ps, 1'b0, st.nsync, st.wide, st.on};
			end else if (hit(avs_req_i.address, `GST_IDX_GCTRL)) begin
				rdv = {st.ge, st.pol, st.tgl, st.spm,
					st.sp != GST_SP_IDLE, st.gate_level, 2'h0};
			end else if (hit(avs_req_i.address, `GST_IDX_GSEL)) begin
				rdv = {3'h0, st.gsel};
			end else if (hit(avs_req_i.address, `GST_IDX_CSEL)) begin
				rdv = {3'h0, st.csel};
			end else if (hit(avs_req_i.address, `GST_IDX_FLAGS)) begin
				rdv = {6'h00, st.gev_fl, st.ovf_fl};
			end
			n.rdata = {24'h000000, rdv};
		end

		// writes land on the accepting edge and beat the counter
		if (acc && avs_req_i.write && avs_req_i.byteenable[0]) begin
			if (hit(avs_req_i.address, `GST_IDX_CNT_LO)) begin
				if (st.wide) n.count = {st.hi_wr_buf, d};
				else n.count[7:0] = d;
			end else if (hit(avs_req_i.address, `GST_IDX_CNT_HI)) begin
				if (st.wide) n.hi_wr_buf = d;
				else n.count[15:8] = d;
			end else if (hit(avs_req_i.address, `GST_IDX_CTRL)) begin
				n.on = d[`GST_CTRL_ON];
				n.wide = d[`GST_CTRL_WIDE];
				n.nsync = d[`GST_CTRL_NSYNC];
				n.ps = d[`GST_CTRL_PS_LSB +: 2];
			end else if (hit(avs_req_i.address, `GST_IDX_GCTRL)) begin
				n.ge = d[`GST_GC_GE];
				n.pol = d[`GST_GC_POL];
				n.tgl = d[`GST_GC_TGL];
				n.spm = d[`GST_GC_SPM];
				if (!d[`GST_GC_SPM] || !d[`GST_GC_ARMED]) begin
					n.sp = GST_SP_IDLE;
				end else if (st.sp == GST_SP_IDLE) begin
					n.sp = GST_SP_ARMED;
				end
			end else if (hit(avs_req_i.address, `GST_IDX_GSEL)) begin
				n.gsel = d[4:0];
			end else if (hit(avs_req_i.address, `GST_IDX_CSEL)) begin
				n.csel = d[4:0];
			end else if (hit(avs_req_i.address, `GST_IDX_FLAGS)) begin
				if (d[`GST_FL_OVF]) n.ovf_fl = 1'b0;
				if (d[`GST_FL_GEV]) n.gev_fl = 1'b0;
			end
		end

		// hardware sets come last so they win over a clear
		if (wrap) begin
			n.ovf_fl = 1'b1;
			n.ovf_pulse = 1'b1;
		end
		if (st.gate_level && !gate_open) n.gev_fl = 1'b1;

		// non-power-on reset keeps count and configuration
		if (soft_rst_i) begin
			n.busy_n = 1'b1;
			n.pre = 3'h0;
			n.ovf_pulse = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
			st.busy_n <= 1'b1;
		end else if (clk_en_i) begin
			st <= n;
		end
	end

	// outputs straight from the state register
	assign avs_readdata_o = st.rdata;
	assign avs_waitrequest_o = st.busy_n;
	assign overflow_o = st.ovf_pulse;
	assign gate_level_o = st.gate_level;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!arst_n_i);

	a_bus_answer: assert property (
		clk_en_i && !soft_rst_i && st.busy_n
		&& (avs_req_i.read || avs_req_i.write) |=> !avs_waitrequest_o)
		else $error("bus request not answered after one stall");
	a_pre_bound: assert property (
		clk_en_i && st.on && tick && st.pre < ps_top(st.ps)
		&& !soft_rst_i |=> !$stable(st.pre))
		else $error("prescaler failed to advance");
	a_off_hold: assert property (
		!st.on && !avs_req_i.write |=> $stable(st.count))
		else $error("count moved while timer off");
	a_free_run: assert property (
		clk_en_i && st.on && !st.ge && psk && !avs_req_i.write
		|=> st.count == $past(st.count) + 16'h0001)
		else $error("free-running count missed a tick");
	a_gate_pol: assert property (
		st.on && st.ge && !st.spm && !st.tgl
		&& (st.pol ? !raw : raw) && !avs_req_i.write
		|=> $stable(st.count))
		else $error("count moved with gate inactive");
	a_tgl_clear: assert property (
		clk_en_i && !st.tgl |=> !st.tff)
		else $error("toggle flop not held clear");
	a_spm_idle: assert property (
		!st.spm |-> st.sp == GST_SP_IDLE)
		else $error("armed while single-pulse mode off");
	a_sp_done: assert property (
		clk_en_i && st.spm && st.sp == GST_SP_RUN && !act
		&& !avs_req_i.write |=> st.sp == GST_SP_IDLE ##1 !st.gate_level)
		else $error("pulse end did not finish acquisition");
	a_wrap_flag: assert property (
		clk_en_i && inc && st.count == `GST_CNT_MAX
		&& !avs_req_i.write && !soft_rst_i |=> st.count == 16'h0000
		&& st.ovf_fl && overflow_o)
		else $error("wrap did not clear count and set flag");
	a_gev_flag: assert property (
		clk_en_i && st.gate_level && !gate_open |=> st.gev_fl)
		else $error("gate falling edge missed");
	a_hi_buf: assert property (
		clk_en_i && cap && st.wide
		&& hit(avs_req_i.address, `GST_IDX_CNT_HI)
		|=> avs_readdata_o[7:0] == $past(st.hi_rd_buf))
		else $error("wide high read not from buffer");
	a_clk_freeze: assert property (
		!clk_en_i |=> st == $past(st))
		else $error("state moved with clock enable low");
	a_busy_once: assert property (
		clk_en_i && !st.busy_n |=> st.busy_n)
		else $error("waitrequest low for more than one cycle");
	a_byte_hi_wr: assert property (
		clk_en_i && acc && avs_req_i.write && avs_req_i.byteenable[0]
		&& !st.wide && hit(avs_req_i.address, `GST_IDX_CNT_HI)
		|=> st.count[15:8] == $past(avs_req_i.writedata[7:0]))
		else $error("byte write missed the high byte");
	a_lo_latch: assert property (
		clk_en_i && cap && st.wide
		&& hit(avs_req_i.address, `GST_IDX_CNT_LO)
		|=> st.hi_rd_buf == $past(st.count[15:8]))
		else $error("low read did not latch high byte");
	a_wide_lo_wr: assert property (
		clk_en_i && acc && avs_req_i.write && avs_req_i.byteenable[0]
		&& st.wide && hit(avs_req_i.address, `GST_IDX_CNT_LO)
		|=> st.count[15:8] == $past(st.hi_wr_buf)
		&& st.count[7:0] == $past(avs_req_i.writedata[7:0]))
		else $error("wide low write did not join the buffer");
	a_wide_hi_wr: assert property (
		clk_en_i && acc && avs_req_i.write && avs_req_i.byteenable[0]
		&& st.wide && hit(avs_req_i.address, `GST_IDX_CNT_HI)
		|=> st.hi_wr_buf == $past(avs_req_i.writedata[7:0]))
		else $error("wide high write not buffered");
	a_arm_write: assert property (
		clk_en_i && acc && avs_req_i.write && avs_req_i.byteenable[0]
		&& hit(avs_req_i.address, `GST_IDX_GCTRL)
		&& st.sp == GST_SP_IDLE
		&& avs_req_i.writedata[`GST_GC_SPM]
		&& avs_req_i.writedata[`GST_GC_ARMED] |=> st.sp == GST_SP_ARMED)
		else $error("arming write did not arm");
	a_armed_wait: assert property (
		clk_en_i && st.spm && st.sp == GST_SP_ARMED && !act
		&& !avs_req_i.write |=> st.sp == GST_SP_ARMED)
		else $error("armed flag dropped before a gate edge");
	a_gate_level_track: assert property (
		clk_en_i && !st.spm |=> st.gate_level == $past(act))
		else $error("gate level bit lost the gate");
	a_tff_toggle: assert property (
		clk_en_i && st.tgl && raw && !st.gate_d
		|=> st.tff != $past(st.tff))
		else $error("toggle flop missed a rising gate edge");
	a_pre_idle: assert property (
		clk_en_i && !st.on && !soft_rst_i |=> $stable(st.pre))
		else $error("prescaler moved while timer off");
	a_soft_keep: assert property (
		clk_en_i && soft_rst_i && !acc
		|=> st.csel == $past(st.csel) && st.gsel == $past(st.gsel)
		&& st.on == $past(st.on) && st.ge == $past(st.ge))
		else $error("soft reset disturbed configuration");
	a_ovf_clear: assert property (
		clk_en_i && acc && avs_req_i.write && avs_req_i.byteenable[0]
		&& hit(avs_req_i.address, `GST_IDX_FLAGS) && !wrap
		&& avs_req_i.writedata[`GST_FL_OVF] |=> !st.ovf_fl)
		else $error("overflow flag not cleared by write");
	a_ovf_hold: assert property (
		clk_en_i && st.ovf_fl && !(acc && avs_req_i.write) |=> st.ovf_fl)
		else $error("overflow flag dropped without a clear");
	a_csel_write: assert property (
		clk_en_i && acc && avs_req_i.write && avs_req_i.byteenable[0]
		&& hit(avs_req_i.address, `GST_IDX_CSEL)
		|=> st.csel == $past(avs_req_i.writedata[4:0]))
		else $error("clock select write lost");

	c_wrap: cover property (overflow_o);
	c_pulse: cover property (st.sp == GST_SP_RUN ##1 st.sp == GST_SP_IDLE);
	c_wide_rd: cover property (cap && st.wide);
	c_gev: cover property (st.gate_level && !gate_open);
	c_freeze: cover property (!clk_en_i ##1 clk_en_i);

endmodule : gst_timer

// file: rtl/gst_map.svh
`ifndef GST_MAP_SVH
`define GST_MAP_SVH

// ---------------------------------------------------------------
// register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define GST_IDX_CNT_LO 12'h30c
`define GST_IDX_CNT_HI 12'h30d
`define GST_IDX_CTRL   12'h30e
`define GST_IDX_GCTRL  12'h30f
`define GST_IDX_GSEL   12'h310
`define GST_IDX_CSEL   12'h311
`define GST_IDX_FLAGS  12'h318

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define GST_CTRL_ON     0
`define GST_CTRL_WIDE   1
`define GST_CTRL_NSYNC  2
`define GST_CTRL_PS_LSB 4
`define GST_GC_LEVEL    2
`define GST_GC_ARMED    3
`define GST_GC_SPM      4
`define GST_GC_TGL      5
`define GST_GC_POL      6
`define GST_GC_GE       7
`define GST_FL_OVF      0
`define GST_FL_GEV      1

// ---------------------------------------------------------------
// reset values, source codes and counts
// ---------------------------------------------------------------
`define GST_RST_COUNT 16'h0000
`define GST_RST_SRC   5'h00
`define GST_CS_PIN    5'h00
`define GST_CS_QSYS   5'h01
`define GST_CS_SYS    5'h02
`define GST_CS_LAST   5'h11
`define GST_GS_LAST   5'h18
`define GST_QDIV_TOP  2'h3
`define GST_CNT_MAX   16'hffff

`endif

// file: rtl/gst_pkg.sv
package gst_pkg;

	// single-pulse acquisition states, gray along idle-armed-run
	typedef enum logic [1:0] {
		GST_SP_IDLE  = 2'h0,
		GST_SP_ARMED = 2'h1,
		GST_SP_RUN   = 2'h3
	} gst_sp_e;

	// avalon-mm request from the master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [11:0] address;
		logic [31:0] writedata;
		logic [3:0]  byteenable;
	} gst_avs_req_s;

	// count clock selector state
	typedef struct packed {
		logic       sync1;
		logic       sync2;
		logic       prev;
		logic [1:0] qdiv;
		logic       tick;
	} gst_tick_s;

	// timer state
	typedef struct packed {
		logic [15:0] count;
		logic [7:0]  hi_rd_buf;
		logic [7:0]  hi_wr_buf;
		logic        on;
		logic        wide;
		logic        nsync;
		logic [1:0]  ps;
		logic        ge;
		logic        pol;
		logic        tgl;
		logic        spm;
		gst_sp_e     sp;
		logic [4:0]  csel;
		logic [4:0]  gsel;
		logic        tff;
		logic        gate_d;
		logic        act_d;
		logic        gate_level;
		logic        ovf_fl;
		logic        gev_fl;
		logic [2:0]  pre;
		logic        busy_n;
		logic [31:0] rdata;
		logic        ovf_pulse;
	} gst_state_s;

endpackage : gst_pkg

// file: rtl/gst_tick_gen.sv
`timescale 1ns/100ps
`include "gst_map.svh"

module gst_tick_gen (
	input  wire logic        clock_i,   // system clock
	input  wire logic        arst_n_i,  // power-on reset
	input  wire logic        clk_en_i,  // freezes state when low
	input  wire logic [17:0] clk_src_i, // count clock sources by code
	input  wire logic [4:0]  sel_i,     // clock source code
	input  wire logic        nsync_i,   // 1: skip synchroniser
	output logic             tick_o     // one-cycle count tick
);
	import gst_pkg::*;

	gst_tick_s st;
	gst_tick_s n;
	logic      src;
	logic      lvl;

	// ---------------------------------------------------------------
	// source mux, synchroniser and edge detect
	// ---------------------------------------------------------------
	always_comb begin
		n = st;
		src = (sel_i <= `GST_CS_LAST) ? clk_src_i[sel_i] : 1'b0;
		n.sync1 = src;
		n.sync2 = st.sync1;
		lvl = nsync_i ? src : st.sync2;
		n.prev = lvl;
		n.qdiv = st.qdiv + 2'h1;
		// system rates bypass the sync bit entirely
		if (sel_i == `GST_CS_SYS) begin
			n.tick = 1'b1;
		end else if (sel_i == `GST_CS_QSYS) begin
			n.tick = (st.qdiv == `GST_QDIV_TOP);
		end else begin
			n.tick = lvl && !st.prev;
		end
	end

	// state register
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			st <= '0;
		end else if (clk_en_i) begin
			st <= n;
		end
	end

	assign tick_o = st.tick;

	a_sys_tick: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && sel_i == `GST_CS_SYS |=> tick_o)
		else $error("system clock source did not tick");
	a_raw_edge: assert property (@(posedge clock_i) disable iff (!arst_n_i)
		clk_en_i && sel_i == `GST_CS_PIN && !nsync_i && st.sync2
		&& !st.prev |=> tick_o)
		else $error("synchronised pin edge lost");

endmodule : gst_tick_gen

// file: dv/gst_src_model.sv
`timescale 1ns/100ps

module gst_src_model (
	input  wire logic        clock_i,   // system clock
	input  wire logic        gate_i,    // wanted gate pin level
	input  wire logic        pin_run_i, // pin clock runs in frames
	output logic      [17:0] clk_src_o, // count clock sources
	output logic      [24:0] gate_src_o // gate sources
);
	logic [3:0] ph;

	// ------------------------------------------------------------
	// source patterns
	// ------------------------------------------------------------
	// pin clock has period four and stands low between frames;
	// unused sources keep moving so a wrong select shows up
	initial begin
		ph = 4'h0;
		clk_src_o = 18'h00000;
		gate_src_o = 25'h0000000;
	end
	always @(posedge clock_i) begin
		ph <= ph + 4'h1;
		clk_src_o <= {{15{ph[0]}}, 2'h0, pin_run_i & ph[1]};
		gate_src_o <= {{24{ph[0]}}, gate_i};
	end
endmodule : gst_src_model

// file: dv/gst_timer_bench.sv
`timescale 1ns/100ps

module gst_timer_bench;
	import gst_pkg::*;

	typedef struct {
		string      what;
		logic [7:0] mask;
		logic [7:0] lo;
		logic [7:0] hi;
	} gst_note_s;

	localparam logic [11:0] adr_lo = 12'hc30;
	localparam logic [11:0] adr_hi = 12'hc34;
	localparam logic [11:0] adr_ct = 12'hc38;
	localparam logic [11:0] adr_gc = 12'hc3c;
	localparam logic [11:0] adr_gs = 12'hc40;
	localparam logic [11:0] adr_cs = 12'hc44;
	localparam logic [11:0] adr_fl = 12'hc60;
	localparam logic [11:0] adr_rst [6] = '{adr_lo, adr_hi, adr_ct,
		adr_gc, adr_gs, adr_cs};

	logic         clock_i, arst_n_i, soft_rst_i, gate, pin_run;
	logic         clk_en;
	gst_avs_req_s avs_req;
	logic [31:0]  rdata;
	logic         wreq, ovf, glvl;
	logic [17:0]  clk_src;
	logic [24:0]  gate_src;
	int           n_fail, comparisons, cycles, n_ovf;
	logic [31:0]  rnd;
	gst_note_s    notes[$];
	gst_note_s    cur;

	gst_src_model u_gst_src_model (.clock_i(clock_i), .gate_i(gate),
		.pin_run_i(pin_run), .clk_src_o(clk_src), .gate_src_o(gate_src));

	gst_timer u_gst_timer (.clock_i(clock_i), .arst_n_i(arst_n_i),
		.clk_en_i(clk_en), .soft_rst_i(soft_rst_i), .avs_req_i(avs_req),
		.clk_src_i(clk_src), .gate_src_i(gate_src),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.overflow_o(ovf), .gate_level_o(glvl));

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic stop_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test

	// range compare; an unknown bit never passes
	task automatic check(input string what, input logic [7:0] seen,
			input logic [7:0] lo, input logic [7:0] hi);
		comparisons++;
		if (^seen === 1'bx || seen < lo || seen > hi) begin
			n_fail++;
			$display("mismatch %s expected %h..%h seen %h", what, lo, hi,
				seen);
		end
	endtask : check

	// ------------------------------------------------------------
	// bus master: hold until waitrequest is seen low
	// ------------------------------------------------------------
	task automatic bus(input logic rd, input logic [11:0] a,
			input logic [7:0] d);
		avs_req <= '{read: rd, write: !rd, address: a,
			writedata: {24'h0, d}, byteenable: 4'hf};
		do @(posedge clock_i); while (wreq !== 1'b0);
		avs_req.read <= 1'b0;
		avs_req.write <= 1'b0;
		@(posedge clock_i);
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		bus(1'b0, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [7:0] m,
			input logic [7:0] lo, input logic [7:0] hi, input string what);
		notes.push_back('{what, m, lo, hi});
		bus(1'b1, a, 8'h00);
	endtask : rd

	// clear count, pick source, switch on; window is closed by stop
	task automatic start(input logic [4:0] cs, input logic [7:0] ctl);
		wr(adr_cs, {3'h0, cs});
		wr(adr_lo, 8'h00);
		wr(adr_hi, 8'h00);
		wr(adr_ct, ctl);
	endtask : start

	task automatic stop(input logic [7:0] lo, input logic [7:0] hi,
			input string what);
		wr(adr_ct, 8'h00);
		rd(adr_lo, 8'hff, lo, hi, what);
	endtask : stop

	// ------------------------------------------------------------
	// result watcher and hang guard
	// ------------------------------------------------------------
	always @(posedge clock_i) begin
		if (avs_req.read && wreq === 1'b0 && notes.size() > 0) begin
			cur = notes.pop_front();
			check(cur.what, rdata[7:0] & cur.mask, cur.lo, cur.hi);
		end
		if (ovf === 1'b1)
			n_ovf++;
		cycles++;
		if (cycles > 8000) begin
			n_fail++;
			stop_test();
		end
	end

	initial begin
		avs_req = '0;
		arst_n_i = 1'b0;
		soft_rst_i = 1'b0;
		clk_en = 1'b1;
		gate = 1'b0;
		pin_run = 1'b0;
		rnd = $urandom(32'h8bbc);
		repeat (5) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		// reset values, unmapped place reads zero and ignores writes
		foreach (adr_rst[i])
			rd(adr_rst[i], 8'hfb, 8'h00, 8'h00, "reset value");
		wr(12'hc48, 8'hff);
		rd(12'hc48, 8'hff, 8'h00, 8'h00, "unmapped");
		// prescale on the system clock: 64 cycles give 64/div
		for (int p = 0; p < 4; p++) begin
			start(5'h02, {2'h0, p[1:0], 4'h1});
			repeat (62) @(posedge clock_i);
			stop(8'(64 >> p) - 8'h2, 8'(64 >> p) + 8'h2, "prescale");
		end
		// clock enable low for 40 cycles takes 40 counts off 65
		start(5'h02, 8'h01);
		repeat (10) @(posedge clock_i);
		clk_en <= 1'b0;
		repeat (40) @(posedge clock_i);
		clk_en <= 1'b1;
		repeat (12) @(posedge clock_i);
		stop(8'd23, 8'd27, "clock enable");
		// quarter rate ignores sync bit, pin clock with and without sync
		for (int s = 0; s < 2; s++) begin
			start(5'h01, {5'h0, s[0], 2'h1});
			repeat (62) @(posedge clock_i);
			stop(8'd14, 8'd18, "quarter rate");
			pin_run <= 1'b1;
			start(5'h00, {5'h0, s[0], 2'h1});
			repeat (62) @(posedge clock_i);
			stop(8'd14, 8'd18, "pin clock");
			pin_run <= 1'b0;
		end
		// gate level shows with gate enable clear
		wr(adr_gs, 8'h00);
		wr(adr_gc, 8'h40);
		gate <= 1'b1;
		repeat (4) @(posedge clock_i);
		rd(adr_gc, 8'h04, 8'h04, 8'h04, "gate level");
		check("gate level pin", {7'h0, glvl}, 8'h01, 8'h01);
		// gate high-active holds, then counts; low-active counts at 0
		wr(adr_gc, 8'hc0);
		gate <= 1'b0;
		start(5'h02, 8'h01);
		repeat (62) @(posedge clock_i);
		stop(8'd0, 8'd0, "gate shut");
		gate <= 1'b1;
		start(5'h02, 8'h01);
		repeat (62) @(posedge clock_i);
		stop(8'd62, 8'd66, "gate open");
		// clear an event left by earlier polarity changes first
		wr(adr_fl, 8'h02);
		gate <= 1'b0;
		repeat (4) @(posedge clock_i);
		check("gate level pin", {7'h0, glvl}, 8'h00, 8'h00);
		rd(adr_fl, 8'h02, 8'h02, 8'h02, "gate event");
		wr(adr_fl, 8'h03);
		rd(adr_fl, 8'h03, 8'h00, 8'h00, "flags cleared");
		wr(adr_gc, 8'h80);
		start(5'h02, 8'h01);
		repeat (62) @(posedge clock_i);
		stop(8'd62, 8'd66, "low active");
		// single pulse: one pulse counted, the second blocked
		wr(adr_gc, 8'hd8);
		rd(adr_gc, 8'h08, 8'h08, 8'h08, "armed");
		start(5'h02, 8'h01);
		gate <= 1'b1;
		repeat (20) @(posedge clock_i);
		gate <= 1'b0;
		repeat (4) @(posedge clock_i);
		rd(adr_gc, 8'h08, 8'h00, 8'h00, "armed done");
		gate <= 1'b1;
		repeat (20) @(posedge clock_i);
		gate <= 1'b0;
		stop(8'd18, 8'd22, "single pulse");
		wr(adr_gc, 8'hd8);
		wr(adr_gc, 8'hc8);
		rd(adr_gc, 8'h08, 8'h00, 8'h00, "mode off");
		// toggle keeps gate open after one short pulse
		wr(adr_gc, 8'he0);
		start(5'h02, 8'h01);
		gate <= 1'b1;
		repeat (4) @(posedge clock_i);
		gate <= 1'b0;
		repeat (30) @(posedge clock_i);
		stop(8'd30, 8'd40, "toggle");
		// toggle off then on again: a stale flop would open the gate
		wr(adr_gc, 8'hc0);
		wr(adr_gc, 8'he0);
		start(5'h02, 8'h01);
		repeat (62) @(posedge clock_i);
		stop(8'd0, 8'd0, "toggle cleared");
		// wide mode: wrap, latched high byte, buffered high write
		wr(adr_gc, 8'h00);
		wr(adr_ct, 8'h02);
		wr(adr_hi, 8'hff);
		wr(adr_lo, 8'hfd);
		wr(adr_ct, 8'h03);
		repeat (6) @(posedge clock_i);
		wr(adr_ct, 8'h02);
		wr(adr_hi, 8'h5a);
		rd(adr_lo, 8'hff, 8'h02, 8'h09, "wrapped low");
		rd(adr_hi, 8'hff, 8'h00, 8'h00, "latched high");
		wr(adr_lo, 8'ha5);
		rd(adr_lo, 8'hff, 8'ha5, 8'ha5, "buffered low");
		rd(adr_hi, 8'hff, 8'h5a, 8'h5a, "buffered high");
		rd(adr_fl, 8'h01, 8'h01, 8'h01, "overflow flag");
		wr(adr_fl, 8'h01);
		rd(adr_fl, 8'h01, 8'h00, 8'h00, "overflow cleared");
		// byte access of a random count survives the soft reset
		wr(adr_ct, 8'h00);
		wr(adr_lo, rnd[7:0]);
		wr(adr_hi, rnd[15:8]);
		wr(adr_gc, 8'h40);
		soft_rst_i <= 1'b1;
		@(posedge clock_i);
		soft_rst_i <= 1'b0;
		@(posedge clock_i);
		rd(adr_lo, 8'hff, rnd[7:0], rnd[7:0], "low kept");
		rd(adr_hi, 8'hff, rnd[15:8], rnd[15:8], "high kept");
		rd(adr_cs, 8'hff, 8'h02, 8'h02, "clock select kept");
		rd(adr_gc, 8'hfb, 8'h40, 8'h40, "gate control kept");
		repeat (4) @(posedge clock_i);
		check("overflow pulses", n_ovf[7:0], 8'h01, 8'h01);
		stop_test();
	end
endmodule : gst_timer_bench
